// ### design/branch_cond.sv
// condition evaluation: decides taken from opcode and status flags
`timescale 1ns/1ps
module branch_cond
	import branch_pkg::*;
(
	input  wire logic [3:0] op_i,
	input  wire logic [2:0] sel_i,
	input  wire logic [7:0] flags_i,
	output logic            taken_o
);
	wire logic sel_bit = flags_i[sel_i];
	wire logic n_xor_v = flags_i[FLAG_N] ^ flags_i[FLAG_V];

	always_comb begin
		case (op_i)
			OP_SEL_SET:   taken_o = sel_bit;
			OP_SEL_CLEAR: taken_o = ~sel_bit;
			OP_EQUAL:     taken_o = flags_i[FLAG_Z];
			OP_NOT_EQUAL: taken_o = ~flags_i[FLAG_Z];
			OP_CARRY_SET,
			OP_LOWER:     taken_o = flags_i[FLAG_C];
			OP_CARRY_CLR,
			OP_SAME_HIGH: taken_o = ~flags_i[FLAG_C];
			OP_MINUS:     taken_o = flags_i[FLAG_N];
			OP_PLUS:      taken_o = ~flags_i[FLAG_N];
			OP_SIGNED_GE: taken_o = ~n_xor_v;
			OP_SIGNED_LT: taken_o = n_xor_v;
			OP_HALF_SET:  taken_o = flags_i[FLAG_H];
			// unknown opcodes fall through
			default:      taken_o = 1'b0;
		endcase
	end
endmodule // branch_cond

// ### design/branch_eval.sv
// conditional branch evaluator with wishbone register access
`timescale 1ns/1ps
module branch_eval
	import branch_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             taken_o,
	output logic             done_o,
	output logic [PC_W-1:0]  next_pc_o
);
	logic [7:0]      flags_r;
	logic [PC_W-1:0] pc_r;
	branch_cmd_t     cmd_r;
	branch_res_t     res_r;
	seq_state_t      state_r;
	seq_state_t      state_nxt;
	logic            ack_r;
	logic [31:0]     dat_r;
	logic            done_r;

	wire logic req     = cyc_i & stb_i & ~ack_r;
	wire logic wr      = req & we_i;
	wire logic idle    = (state_r == ST_IDLE);
	wire logic wr_flag = wr & (adr_i == REG_FLAGS) & sel_i[0] & idle;
	wire logic wr_pc   = wr & (adr_i == REG_PC) & (&sel_i[1:0]) & idle;
	wire logic wr_cmd  = wr & (adr_i == REG_CMD) & (&sel_i[1:0]) & idle;

	wire logic            cond_taken;
	wire logic [PC_W-1:0] tgt;
	wire logic [PC_W-1:0] seq;

	branch_cond u_cond (
		.op_i    (cmd_r.op),
		.sel_i   (cmd_r.sel),
		.flags_i (flags_r),
		.taken_o (cond_taken)
	);

	branch_target u_tgt (
		.pc_i     (pc_r),
		.off_i    (cmd_r.off),
		.target_o (tgt),
		.seq_o    (seq)
	);

	always_comb begin
		case (state_r)
			ST_IDLE:  state_nxt = wr_cmd ? ST_EVAL : ST_IDLE;
			ST_EVAL:  state_nxt = cond_taken ? ST_TAKEN : ST_IDLE;
			ST_TAKEN: state_nxt = ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	wire logic [31:0] rd_data =
		(adr_i == REG_FLAGS)  ? {24'h0000_00, flags_r} :
		(adr_i == REG_PC)     ? {16'h0000, pc_r} :
		(adr_i == REG_CMD)    ? {17'h0_0000, cmd_r.off, 1'b0, cmd_r.sel, cmd_r.op} :
		(adr_i == REG_STATUS) ? {29'h0000_0000, ~idle, res_r.taken, done_r} :
		32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			ack_r   <= 1'b0;
			dat_r   <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			// unmapped addresses still ack and read zero
			ack_r   <= req;
			dat_r   <= rd_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			flags_r <= FLAGS_RST;
		else if (wr_flag)
			flags_r <= dat_i[7:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cmd_r <= '0;
		else if (wr_cmd) begin
			cmd_r.op  <= dat_i[CMD_OP_LSB +: 4];
			cmd_r.sel <= dat_i[CMD_SEL_LSB +: 3];
			cmd_r.off <= dat_i[CMD_OFF_LSB +: OFF_W];
		end
	end

	// apart from pc writes in idle, the counter moves only when the decision completes, never mid-branch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_r   <= PC_RST;
			res_r  <= '0;
			done_r <= 1'b0;
		end else if (wr_pc) begin
			pc_r <= dat_i[PC_W-1:0];
		end else if (state_r == ST_EVAL) begin
			res_r.taken   <= cond_taken;
			res_r.next_pc <= cond_taken ? tgt : seq;
			done_r        <= ~cond_taken;
			if (!cond_taken)
				pc_r <= seq;
		end else if (state_r == ST_TAKEN) begin
			pc_r   <= res_r.next_pc;
			done_r <= 1'b1;
		end else if (wr_cmd) begin
			done_r <= 1'b0;
		end
	end

	assign ack_o     = ack_r;
	assign dat_o     = dat_r;
	assign taken_o   = res_r.taken;
	assign done_o    = done_r;
	assign next_pc_o = pc_r;
endmodule // branch_eval

// ### design/branch_target.sv
// target address: pc plus sign-extended offset plus one
`timescale 1ns/1ps
module branch_target
	import branch_pkg::*;
(
	input  wire logic [PC_W-1:0]  pc_i,
	input  wire logic [OFF_W-1:0] off_i,
	output logic      [PC_W-1:0]  target_o,
	output logic      [PC_W-1:0]  seq_o
);
	wire logic [PC_W-1:0] off_ext = {{(PC_W-OFF_W){off_i[OFF_W-1]}}, off_i};

	// wraps around the program space, as the counter itself does
	assign target_o = pc_i + off_ext + 16'h0001;
	assign seq_o    = pc_i + 16'h0001;
endmodule // branch_target

// ### pkg/branch_pkg.sv
// package for the conditional branch evaluator: opcodes, flags, register map
package branch_pkg;

	localparam int PC_W  = 16;
	localparam int OFF_W = 7;

	// status flag bit positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_H = 3'h5;

	// branch kinds, as written by software into the command register
	localparam logic [3:0] OP_SEL_SET   = 4'h0;
	localparam logic [3:0] OP_SEL_CLEAR = 4'h1;
	localparam logic [3:0] OP_EQUAL     = 4'h2;
	localparam logic [3:0] OP_NOT_EQUAL = 4'h3;
	localparam logic [3:0] OP_CARRY_SET = 4'h4;
	localparam logic [3:0] OP_LOWER     = 4'h5;
	localparam logic [3:0] OP_CARRY_CLR = 4'h6;
	localparam logic [3:0] OP_SAME_HIGH = 4'h7;
	localparam logic [3:0] OP_MINUS     = 4'h8;
	localparam logic [3:0] OP_PLUS      = 4'h9;
	localparam logic [3:0] OP_SIGNED_GE = 4'hA;
	localparam logic [3:0] OP_SIGNED_LT = 4'hB;
	localparam logic [3:0] OP_HALF_SET  = 4'hC;

	// register byte offsets
	localparam logic [3:0] REG_FLAGS  = 4'h0;
	localparam logic [3:0] REG_PC     = 4'h4;
	localparam logic [3:0] REG_CMD    = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;

	// command word fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_SEL_LSB = 4;
	localparam int CMD_OFF_LSB = 8;

	// reset values
	localparam logic [7:0]      FLAGS_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST    = 16'h0000;

	// cycles taken by a branch
	localparam int CYC_NOT_TAKEN = 1;
	localparam int CYC_TAKEN     = 2;

	typedef struct packed {
		logic [3:0]       op;
		logic [2:0]       sel;
		logic [OFF_W-1:0] off;
	} branch_cmd_t;

	typedef struct packed {
		logic            taken;
		logic [PC_W-1:0] next_pc;
	} branch_res_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_EVAL  = 3'b010,
		ST_TAKEN = 3'b100
	} seq_state_t;

endpackage

// ### verification/branch_eval_properties.sv
// port checker for the conditional branch evaluator
`timescale 1ns/1ps
module branch_eval_properties
	import branch_pkg::*;
(
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             cyc_i,
	input wire logic             stb_i,
	input wire logic             we_i,
	input wire logic [3:0]       adr_i,
	input wire logic [3:0]       sel_i,
	input wire logic [31:0]      dat_i,
	input wire logic [31:0]      dat_o,
	input wire logic             ack_o,
	input wire logic             taken_o,
	input wire logic             done_o,
	input wire logic [PC_W-1:0]  next_pc_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire            cmd_ack = ack_o && we_i && adr_i == REG_CMD && sel_i[1:0] == 2'h3;
	wire [PC_W-1:0] k_ext   = {{(PC_W-OFF_W){dat_i[14]}}, dat_i[14:8]};

	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	a_branch_cycles: assert property (
		cmd_ack |=> (done_o != taken_o) ##1 done_o) else $error("branch cycle count wrong");
	a_target_pc: assert property (
		cmd_ack |=> ##1 next_pc_o == $past(next_pc_o, 2) + (taken_o ? $past(k_ext, 2) : 16'h0000)
		+ 16'h0001) else $error("next pc wrong");
	// pc only moves as a result of a bus write
	a_pc_quiet: assert property (!(cyc_i && stb_i && we_i) [*3] |-> $stable(next_pc_o))
		else $error("pc moved without a command");
	a_taken_cause: assert property ($rose(taken_o) |-> $past(ack_o)) else $error("taken uncaused");
	a_status_read: assert property (ack_o && !we_i && adr_i == REG_STATUS
		&& $stable({taken_o, done_o}) |-> dat_o[1:0] == {taken_o, done_o})
		else $error("status readback wrong");
	a_unmapped_zero: assert property (ack_o && !we_i && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // branch_eval_properties

bind branch_eval branch_eval_properties branch_eval_properties_inst (.clk_i, .rst_i, .cyc_i,
	.stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .taken_o, .done_o, .next_pc_o);

// ### verification/tb_branch_eval.sv
// self-checking bench for the branch evaluator
`timescale 1ns/1ps
module tb_branch_eval
	import branch_pkg::*;
;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	logic             clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0]       adr_i = 4'h0, sel_i = 4'h0;
	logic [31:0]      dat_i = ZERO, dat_o, q;
	logic             ack_o, taken_o, done_o, tk;
	logic [PC_W-1:0]  next_pc_o, pc;
	logic [7:0]       fl;
	logic [OFF_W-1:0] k;
	int               err_total = 0, n_checks = 0, t;

	branch_eval branch_eval_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .taken_o, .done_o, .next_pc_o);

	initial forever #2.5 clk_i = ~clk_i;

	task automatic complete_run();
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask

	// one classic cycle; the idle edge in front keeps cyc low between requests
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int i;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hF, d};
		for (i = 0; i < 20 && ack_o !== 1'b1; i++)
			@(posedge clk_i);
		if (i == 20) begin
			err_total++;
			complete_run();
		end
		r = dat_o;
		{cyc_i, stb_i} <= 2'h0;
	endtask

	function automatic logic exp_t(input logic [3:0] o, input logic [2:0] s, input logic [7:0] f);
		case (o)
			OP_SEL_SET: return f[s];
			OP_SEL_CLEAR: return !f[s];
			OP_EQUAL: return f[FLAG_Z];
			OP_NOT_EQUAL: return !f[FLAG_Z];
			OP_CARRY_SET, OP_LOWER: return f[FLAG_C];
			OP_CARRY_CLR, OP_SAME_HIGH: return !f[FLAG_C];
			OP_MINUS: return f[FLAG_N];
			OP_PLUS: return !f[FLAG_N];
			OP_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
			OP_SIGNED_LT: return f[FLAG_N] ^ f[FLAG_V];
			OP_HALF_SET: return f[FLAG_H];
			default: return 1'b0;
		endcase
	endfunction

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, REG_PC, ZERO, q);
		chk("pc", ZERO, q);
		wb(1'b0, 4'h2, ZERO, q);
		chk("unmapped", ZERO, q);
		for (int o = 0; o < 14; o++) begin
			for (int j = 0; j < 4; j++) begin
				fl = j == 0 ? 8'h00 : j == 1 ? 8'hFF : j == 2 ? 8'h05 : 8'h2A;
				pc = 16'(o * 16'h1234 + j * 16'h4F00);
				k = 7'(o * 9 + j * 37);
				wb(1'b1, REG_FLAGS, 32'(fl), q);
				wb(1'b1, REG_PC, 32'(pc), q);
				wb(1'b1, REG_CMD, {17'h0, k, 1'b0, 3'(o + j * 3), 4'(o)}, q);
				for (t = 0; t < 6 && done_o !== 1'b1; t++)
					@(posedge clk_i);
				if (t == 6) begin
					err_total++;
					complete_run();
				end
				tk = exp_t(4'(o), 3'(o + j * 3), fl);
				chk("taken", 32'(tk), 32'(taken_o));
				// the inner cast keeps the sum at counter width, so it wraps like the counter
				chk("next_pc", 32'(16'(pc + (tk ? {{9{k[6]}}, k} : 16'h0) + 16'h1)), 32'(next_pc_o));
				wb(1'b0, REG_FLAGS, ZERO, q);
				chk("flags", 32'(fl), q);
				wb(1'b0, REG_STATUS, ZERO, q);
				chk("status", {30'h0, tk, 1'b1}, q);
			end
		end
		// mid-run reset: held two edges so no stale pc is compared after release
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("rst_next_pc", 32'(PC_RST), 32'(next_pc_o));
		chk("rst_taken", ZERO, 32'(taken_o));
		chk("rst_done", ZERO, 32'(done_o));
		wb(1'b0, REG_FLAGS, ZERO, q);
		chk("rst_flags", 32'(FLAGS_RST), q);
		wb(1'b0, REG_STATUS, ZERO, q);
		chk("rst_status", ZERO, q);
		complete_run();
	end
endmodule // tb_branch_eval
